// [tb.sv]
`timescale 1ns/1ps
`include "xad_cfg.svh"

module tb;
  // ****************************************************************
  // stimulus and observed signals
  // ****************************************************************
  logic                          core_clk;     // 50 MHz core clock
  logic                          rst;          // sync reset, active high
  logic                          clk_en;       // global enable
  logic [13:0]                   instr;        // instruction word
  logic                          instr_valid;  // word qualifies as instruction
  logic                          bank_sel;     // opens the direction window
  logic [6:0]                    file_rd_addr; // operand address shown
  logic [7:0]                    file_rd_data; // operand data returned
  xad_pkg::xad_file_wr_t         file_wr;      // file write from the block
  xad_pkg::xad_file_wr_t         ext_wr;       // outside write request
  logic [6:0]                    ext_rd_addr;  // outside read address
  logic [7:0]                    ext_rd_data;  // outside read data
  logic [7:0]                    acc;          // accumulator
  logic                          zero_flag;    // zero flag
  xad_pkg::xad_phase_t           q_phase;      // quarter phase
  logic [`XAD_DIR_NUM-1:0][7:0]  dir_out;      // direction registers
  int                            fails;        // mismatch count
  int                            tests_run;    // comparison count
  xad_pkg::xad_file_wr_t         wr_seen;      // file write caught in Q4
  logic [6:0]                    ad_seen;      // operand address caught in Q4

  xad_exec dut (
    .core_clk     (core_clk),
    .rst          (rst),
    .clk_en       (clk_en),
    .instr        (instr),
    .instr_valid  (instr_valid),
    .bank_sel     (bank_sel),
    .file_rd_addr (file_rd_addr),
    .file_rd_data (file_rd_data),
    .file_wr      (file_wr),
    .ext_wr       (ext_wr),
    .ext_rd_addr  (ext_rd_addr),
    .ext_rd_data  (ext_rd_data),
    .acc          (acc),
    .zero_flag    (zero_flag),
    .q_phase      (q_phase),
    .dir_out      (dir_out)
  );

  // half period of 10 ns gives 50 MHz
  always #10 core_clk = ~core_clk;

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  // one comparison, four-state exact
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task close_out;
    if (fails == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  // one full instruction cycle; inputs move only on falling edges
  task op(input logic v, input logic [13:0] w, input logic [7:0] rd);
    // idle quarters may have passed since the last call; start on a Q1 boundary
    while (q_phase !== xad_pkg::XAD_PH_Q1) begin
      @(negedge core_clk);
    end
    instr        = w;
    instr_valid  = v;
    file_rd_data = rd;
    @(negedge core_clk);
    // the Q1 edge has taken the word; dropping valid here keeps the next call
    // from lowering and raising it in one time step
    instr_valid = 1'b0;
    repeat (2) @(negedge core_clk);
    // third edge done: Q4 is the cycle where the write stands
    wr_seen = file_wr;
    ad_seen = file_rd_addr;
    @(negedge core_clk);
  endtask : op

  // check accumulator and zero flag together
  task chk_acc(input logic [7:0] a, input logic z);
    chk({8'h00, acc}, {8'h00, a});
    chk({15'h0000, zero_flag}, {15'h0000, z});
  endtask : chk_acc

  // ****************************************************************
  // scenarios
  // ****************************************************************
  // literal xor, back to back, both zero flag outcomes
  task t_lit;
    op(1'b1, 14'h3A5A, 8'h00);
    chk_acc(8'h5A, 1'b0);
    op(1'b1, 14'h3A5A, 8'h00);
    chk_acc(8'h00, 1'b1);
    chk({14'h0000, q_phase}, 16'h0000);
  endtask : t_lit

  // direction load: select below range ignored, flag kept
  task t_dir;
    op(1'b1, 14'h0064, 8'h00);
    chk({dir_out[2], dir_out[1]}, 16'hFFFF);
    op(1'b1, 14'h0066, 8'h00);
    chk({dir_out[1], dir_out[0]}, 16'h00FF);
    chk_acc(8'h00, 1'b1);
  endtask : t_dir

  // file xor to accumulator, then back to file with a zero result
  task t_file;
    bank_sel = 1'b0;
    op(1'b1, 14'h3AB5, 8'h00);
    op(1'b1, 14'h0620, 8'hAF);
    chk({9'h000, ad_seen}, 16'h0020);
    chk_acc(8'h1A, 1'b0);
    chk({15'h0000, wr_seen.en}, 16'h0000);
    // window closed: 0x05 is a plain file register here
    op(1'b1, 14'h0685, 8'h1A);
    chk(wr_seen, 16'h8500);
    chk_acc(8'h1A, 1'b1);
    chk({8'h00, dir_out[0]}, 16'h00FF);
  endtask : t_file

  // invalid cycle does nothing
  task t_noop;
    op(1'b0, 14'h3AFF, 8'h00);
    chk_acc(8'h1A, 1'b1);
    chk({15'h0000, wr_seen.en}, 16'h0000);
  endtask : t_noop

  // direction registers as file registers, both ways
  task t_window;
    bank_sel = 1'b1;
    ext_wr   = '{en: 1'b1, addr: 7'h06, data: 8'h3C};
    @(negedge core_clk);
    ext_wr      = '{en: 1'b0, addr: 7'h00, data: 8'h00};
    ext_rd_addr = 7'h06;
    chk({8'h00, dir_out[1]}, 16'h003C);
    @(negedge core_clk);
    chk({8'h00, ext_rd_data}, 16'h003C);
    // d=1 on 0x07 writes the register itself; bus data is ignored
    op(1'b1, 14'h0687, 8'h00);
    chk({15'h0000, wr_seen.en}, 16'h0000);
    chk({8'h00, dir_out[2]}, 16'h00E5);
    chk_acc(8'h1A, 1'b0);
    op(1'b1, 14'h0606, 8'h00);
    chk_acc(8'h26, 1'b0);
  endtask : t_window

  // enable low holds everything, phase included
  task t_freeze;
    clk_en      = 1'b0;
    instr       = 14'h3A26;
    instr_valid = 1'b1;
    repeat (5) @(negedge core_clk);
    chk({14'h0000, q_phase}, 16'h0000);
    chk_acc(8'h26, 1'b0);
    clk_en = 1'b1;
    op(1'b1, 14'h3A26, 8'h00);
    chk_acc(8'h00, 1'b1);
  endtask : t_freeze

  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial begin
    core_clk     = 1'b0;
    rst          = 1'b1;
    clk_en       = 1'b1;
    instr        = 14'h0000;
    instr_valid  = 1'b0;
    bank_sel     = 1'b0;
    file_rd_data = 8'h00;
    ext_wr       = '{en: 1'b0, addr: 7'h00, data: 8'h00};
    ext_rd_addr  = 7'h00;
    fails        = 0;
    tests_run    = 0;
    repeat (16) @(negedge core_clk);
    rst = 1'b0;
    chk({dir_out[2], dir_out[0]}, 16'hFFFF);
    chk_acc(8'h00, 1'b0);
    t_lit();
    t_dir();
    t_file();
    t_noop();
    t_window();
    t_freeze();
    close_out();
  end

  // the whole run needs well under 200 cycles
  initial begin
    #40000;
    fails++;
    close_out();
  end
endmodule : tb

// [xad_cfg.svh]
// Overview of operation
// RULE1: direction load copies accumulator, registers 5-7
// RULE2: direction registers also reachable as file registers
// RULE3: literal XOR, opcode 1010, result to accumulator
// RULE4: one cycle: decode, read, compute, write
// RULE5: file XOR, destination 0 writes accumulator
// RULE6: destination 1 writes file, accumulator kept
// RULE7: XOR sets zero flag; direction load doesn't
`ifndef XAD_CFG_SVH
`define XAD_CFG_SVH

// ****************************************************************
// opcode fields of the 14-bit instruction word
// ****************************************************************
`define XAD_OP_DIR_HI     11'h00C
`define XAD_OP_XLIT_HI    6'h3A
`define XAD_OP_XFILE_HI   6'h06
`define XAD_DEST_BIT      7
`define XAD_DIR_SEL_LO    3'h5
`define XAD_DIR_SEL_HI    3'h7

// ****************************************************************
// direction registers in the file space and reset values
// ****************************************************************
`define XAD_DIR_NUM       3
`define XAD_DIR_FILE_BASE 7'h05
`define XAD_DIR_RST       8'hFF
`define XAD_ACC_RST       8'h00

// ****************************************************************
// timing
// ****************************************************************
`define XAD_QUARTERS      4

`endif

// [xad_exec.sv]
`timescale 1ns/1ps
`include "xad_cfg.svh"

module xad_exec (
  // clock, reset, enable
  input  wire logic                    core_clk,
  input  wire logic                    rst,
  input  wire logic                    clk_en,
  // instruction from the pipeline, held through the cycle
  input  wire logic [13:0]             instr,
  input  wire logic                    instr_valid,
  // bank select for the direction register window
  input  wire logic                    bank_sel,
  // file register read path
  output logic [6:0]                   file_rd_addr,
  input  wire logic [7:0]              file_rd_data,
  // file register write path
  output xad_pkg::xad_file_wr_t        file_wr,
  // other core accesses to the file space
  input  wire xad_pkg::xad_file_wr_t   ext_wr,
  input  wire logic [6:0]              ext_rd_addr,
  output logic [7:0]                   ext_rd_data,
  // core state
  output logic [7:0]                   acc,
  output logic                         zero_flag,
  output xad_pkg::xad_phase_t          q_phase,
  output logic [`XAD_DIR_NUM-1:0][7:0] dir_out
);

  // ****************************************************************
  // decode helpers
  // ****************************************************************

  // classify an instruction word; unknown words do nothing here
  function automatic xad_pkg::xad_op_t decode_op(input logic [13:0] w);
    xad_pkg::xad_op_t op;
    op = xad_pkg::XAD_OP_NONE;
    if (w[13:3] == `XAD_OP_DIR_HI && w[2:0] >= `XAD_DIR_SEL_LO) begin
      op = xad_pkg::XAD_OP_DIR;
    end else if (w[13:8] == `XAD_OP_XLIT_HI) begin
      op = xad_pkg::XAD_OP_XLIT;
    end else if (w[13:8] == `XAD_OP_XFILE_HI) begin
      op = xad_pkg::XAD_OP_XFILE;
    end
    return op;
  endfunction : decode_op

  // file address falls on a direction register
  function automatic logic dir_hit(input logic [6:0] a, input logic bank);
    return bank && (a >= `XAD_DIR_FILE_BASE) && (a < `XAD_DIR_FILE_BASE + 7'h03);
  endfunction : dir_hit

  // direction register index of a file address
  function automatic logic [1:0] dir_idx(input logic [6:0] a);
    logic [6:0] d;
    d = a - `XAD_DIR_FILE_BASE;
    return d[1:0];
  endfunction : dir_idx

  // ****************************************************************
  // pipeline state
  // ****************************************************************
  xad_pkg::xad_phase_t          phase_r, phase_nxt;        // quarter phase
  xad_pkg::xad_op_t             op_r, op_nxt;              // latched operation
  logic [13:0]                  instr_r, instr_nxt;        // latched word
  logic [7:0]                   operand_r, operand_nxt;    // literal or file value
  logic [7:0]                   result_r, result_nxt;      // computed value
  logic [7:0]                   acc_r, acc_nxt;            // working accumulator
  logic                         zero_r, zero_nxt;          // zero flag
  xad_pkg::xad_file_wr_t        file_wr_r, file_wr_nxt;    // outbound write
  logic [`XAD_DIR_NUM-1:0][7:0] dir_r, dir_nxt;            // direction registers
  logic [7:0]                   ext_rd_r, ext_rd_nxt;      // registered read data
  logic                         op_hit;                    // operand is a direction reg
  logic                         dest_file;                 // destination bit set
  logic [1:0]                   dir_sel;                   // target of direction load
  logic [1:0]                   op_idx;                    // index of operand reg

  assign op_hit       = dir_hit(instr_r[6:0], bank_sel);
  assign op_idx       = dir_idx(instr_r[6:0]);
  assign dest_file    = instr_r[`XAD_DEST_BIT];
  assign dir_sel      = 2'(instr_r[2:0] - `XAD_DIR_SEL_LO);
  assign file_rd_addr = instr_r[6:0];

  // ****************************************************************
  // phase sequencing and operand path
  // ****************************************************************

  // four quarters per instruction; data moves one step per quarter
  always_comb begin
    phase_nxt   = phase_r;
    op_nxt      = op_r;
    instr_nxt   = instr_r;
    operand_nxt = operand_r;
    result_nxt  = result_r;
    case (phase_r)
      xad_pkg::XAD_PH_Q1: begin                             // RULE4
        phase_nxt = xad_pkg::XAD_PH_Q2;
        instr_nxt = instr;
        op_nxt    = instr_valid ? decode_op(instr) : xad_pkg::XAD_OP_NONE;
      end
      xad_pkg::XAD_PH_Q2: begin
        phase_nxt = xad_pkg::XAD_PH_Q3;
        if (op_r == xad_pkg::XAD_OP_XLIT) begin
          operand_nxt = instr_r[7:0];                       // RULE3
        end else if (op_hit) begin
          operand_nxt = dir_r[op_idx];                      // RULE2
        end else begin
          operand_nxt = file_rd_data;                       // RULE5
        end
      end
      xad_pkg::XAD_PH_Q3: begin
        phase_nxt = xad_pkg::XAD_PH_Q4;
        // direction load passes the accumulator through untouched
        result_nxt = (op_r == xad_pkg::XAD_OP_DIR) ? acc_r : (acc_r ^ operand_r);
      end
      xad_pkg::XAD_PH_Q4: begin
        phase_nxt = xad_pkg::XAD_PH_Q1;
      end
      default: begin
        phase_nxt = xad_pkg::XAD_PH_Q1;
      end
    endcase
  end

  // ****************************************************************
  // destination writes
  // ****************************************************************

  // the outbound write is registered in Q3 so it stands during Q4
  always_comb begin
    acc_nxt     = acc_r;
    zero_nxt    = zero_r;
    dir_nxt     = dir_r;
    file_wr_nxt = '0;
    ext_rd_nxt  = ext_rd_r;
    // other core writes reach the direction registers as files
    if (ext_wr.en && dir_hit(ext_wr.addr, bank_sel)) begin
      dir_nxt[dir_idx(ext_wr.addr)] = ext_wr.data;          // RULE2
    end
    if (dir_hit(ext_rd_addr, bank_sel)) begin
      ext_rd_nxt = dir_r[dir_idx(ext_rd_addr)];             // RULE2
    end else begin
      ext_rd_nxt = 8'h00;
    end
    if (phase_r == xad_pkg::XAD_PH_Q3 && op_r == xad_pkg::XAD_OP_XFILE && dest_file && !op_hit) begin
      file_wr_nxt.en   = 1'b1;                              // RULE6
      file_wr_nxt.addr = instr_r[6:0];
      file_wr_nxt.data = acc_r ^ operand_r;
    end
    if (phase_r == xad_pkg::XAD_PH_Q4) begin
      // instruction write wins over a same-cycle outside write
      case (op_r)
        xad_pkg::XAD_OP_DIR: begin
          dir_nxt[dir_sel] = result_r;                      // RULE1
        end
        xad_pkg::XAD_OP_XLIT: begin
          acc_nxt  = result_r;                              // RULE3
          zero_nxt = (result_r == 8'h00);                   // RULE7
        end
        xad_pkg::XAD_OP_XFILE: begin
          zero_nxt = (result_r == 8'h00);                   // RULE7
          if (!dest_file) begin
            acc_nxt = result_r;                             // RULE5
          end else if (op_hit) begin
            dir_nxt[op_idx] = result_r;                     // RULE6
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************

  // everything holds while the clock enable is low
  always_ff @(posedge core_clk) begin
    if (rst) begin
      phase_r   <= xad_pkg::XAD_PH_Q1;
      op_r      <= xad_pkg::XAD_OP_NONE;
      instr_r   <= 14'h0000;
      operand_r <= 8'h00;
      result_r  <= 8'h00;
      acc_r     <= `XAD_ACC_RST;
      zero_r    <= 1'b0;
      file_wr_r <= '0;
      ext_rd_r  <= 8'h00;
      dir_r     <= {`XAD_DIR_NUM{`XAD_DIR_RST}};
    end else if (clk_en) begin
      phase_r   <= phase_nxt;
      op_r      <= op_nxt;
      instr_r   <= instr_nxt;
      operand_r <= operand_nxt;
      result_r  <= result_nxt;
      acc_r     <= acc_nxt;
      zero_r    <= zero_nxt;
      file_wr_r <= file_wr_nxt;
      ext_rd_r  <= ext_rd_nxt;
      dir_r     <= dir_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign acc         = acc_r;
  assign zero_flag   = zero_r;
  assign q_phase     = phase_r;
  assign file_wr     = file_wr_r;
  assign ext_rd_data = ext_rd_r;
  assign dir_out     = dir_r;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // an instruction word taken at Q1 followed by three enabled quarters
  sequence s_run(xad_pkg::xad_op_t k);
    (phase_r == xad_pkg::XAD_PH_Q1 && clk_en && instr_valid && decode_op(instr) == k) ##1 clk_en [*3];
  endsequence

  chk_dir_load_value: assert property (s_run(xad_pkg::XAD_OP_DIR) |=> // RULE1
    dir_r[$past(dir_sel, 3)] == $past(acc_r, 4) && zero_r == $past(zero_r, 4))
    else $error("direction load did not copy accumulator");

  chk_dir_file_read: assert property (clk_en && dir_hit(ext_rd_addr, bank_sel) |=> // RULE2
    ext_rd_data == $past(dir_r[dir_idx(ext_rd_addr)]))
    else $error("direction register read as file wrong");

  chk_xlit_result: assert property (s_run(xad_pkg::XAD_OP_XLIT) |=> // RULE3
    acc_r == ($past(acc_r, 4) ^ $past(instr[7:0], 4)))
    else $error("literal xor result wrong");

  chk_phase_order: assert property (phase_r == xad_pkg::XAD_PH_Q1 && clk_en |=> // RULE4
    phase_r == xad_pkg::XAD_PH_Q2)
    else $error("quarter phase out of order");

  chk_acc_only_q4: assert property (!(phase_r == xad_pkg::XAD_PH_Q4 && clk_en) |=> // RULE4
    $stable(acc_r))
    else $error("accumulator changed outside Q4");

  chk_xfile_to_acc: assert property ((phase_r == xad_pkg::XAD_PH_Q2 && clk_en && // RULE5
    op_r == xad_pkg::XAD_OP_XFILE && !dest_file && !op_hit) ##1 clk_en [*2] |=>
    acc_r == ($past(acc_r, 3) ^ $past(file_rd_data, 3)))
    else $error("file xor to accumulator wrong");

  chk_xfile_to_file: assert property ((phase_r == xad_pkg::XAD_PH_Q3 && clk_en && // RULE6
    op_r == xad_pkg::XAD_OP_XFILE && dest_file && !op_hit) |=>
    file_wr.en && file_wr.data == ($past(acc_r) ^ $past(operand_r)) ##1 $stable(acc_r))
    else $error("file xor write back wrong");

  chk_zero_update: assert property (phase_r == xad_pkg::XAD_PH_Q4 && clk_en && // RULE7
    (op_r == xad_pkg::XAD_OP_XLIT || op_r == xad_pkg::XAD_OP_XFILE) |=>
    zero_r == ($past(result_r) == 8'h00))
    else $error("zero flag not set from result");

endmodule : xad_exec

// [xad_pkg.sv]
// ****************************************************************
// shared types
// ****************************************************************
package xad_pkg;

  // decoded operation
  typedef enum logic [1:0] {
    XAD_OP_NONE,
    XAD_OP_DIR,
    XAD_OP_XLIT,
    XAD_OP_XFILE
  } xad_op_t;

  // quarter phase of the instruction cycle
  typedef enum logic [1:0] {
    XAD_PH_Q1,
    XAD_PH_Q2,
    XAD_PH_Q3,
    XAD_PH_Q4
  } xad_phase_t;

  // one file register write
  typedef struct packed {
    logic       en;
    logic [6:0] addr;
    logic [7:0] data;
  } xad_file_wr_t;

endpackage : xad_pkg
